// file: core/fbd_decoder.sv
/*
  fieldbus drive command decoder: latches the bus command word and speed
  reference, decodes stop, start, hold, reset, jog, trim, set and reverse
  requests, and returns the actual frequency in reference scaling.
  assumes one synchronous clock, synchronous active-high reset, APB host.
*/
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fbd_decoder (
  input wire logic i_clk_sys, // system clock, 40 MHz
  input wire logic i_srst, // synchronous reset, active high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb write
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped address
  input wire logic i_din_coast_n, // digital input coast, low coasts
  input wire logic i_din_qstop_n, // digital input quick stop, low stops
  input wire logic i_din_start, // digital input start
  input wire logic i_din_rev, // digital input reverse
  input wire logic [1:0] i_din_set, // digital input set selection
  input wire logic i_running, // motor running
  input wire logic i_zero_freq, // output frequency is 0 Hz
  input wire logic signed [15:0] i_out_freq_rel, // actual frequency, relative
  output logic o_ramp_stop, // normal ramp stop request
  output logic o_coast, // coast request
  output logic o_quick_stop, // quick stop request
  output logic o_hold, // freeze output frequency
  output logic o_start_ok, // start permitted
  output logic o_fault_reset, // one-cycle fault reset pulse
  output logic o_jog1, // jog 1 speed select
  output logic o_jog2, // jog 2 speed select
  output logic o_reverse, // reverse direction
  output logic [1:0] o_active_set, // active parameter set, 0 is set 1
  output logic signed [15:0] o_speed_ref, // trimmed speed reference
  output logic o_stop_relay // output relay at standstill
);
  import fbd_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] cmd_reg, cmd_next;
  logic signed [15:0] ref_reg, ref_next;
  logic [15:0] pend_cmd_reg;
  logic [31:0] cfg_reg;
  logic signed [15:0] trim_reg;
  logic [3:0] link_reg;
  logic reset_prev_reg;
  logic fault_reset_reg;
  logic [1:0] set_reg, set_next;
  logic signed [15:0] ref_out_reg;
  logic [15:0] freq_reg;
  logic [15:0] drop_cnt_reg;

  // ****************************************
  // bus decode
  // ****************************************
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire hit_cmd = (i_paddr == FBD_OFF_CMD);
  wire hit_ref = (i_paddr == FBD_OFF_REF);
  wire hit_cfg = (i_paddr == FBD_OFF_CFG);
  wire hit_trim = (i_paddr == FBD_OFF_TRIM);
  wire hit_stat = (i_paddr == FBD_OFF_STAT);
  wire hit_freq = (i_paddr == FBD_OFF_FREQ);
  wire hit_req = (i_paddr == FBD_OFF_REQ);
  wire hit_link = (i_paddr == FBD_OFF_LINK);
  wire mapped = hit_cmd | hit_ref | hit_cfg | hit_trim | hit_stat | hit_freq | hit_req | hit_link;
  // writing the reference commits the telegram pending in the command reg
  wire telegram = wr && hit_ref;
  wire [15:0] tel_cmd = pend_cmd_reg;
  wire tel_valid = telegram && tel_cmd[FBD_B_VALID];

  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;

  // ****************************************
  // gating helpers
  // ****************************************
  function automatic logic fbd_gate(input logic [1:0] src, input logic bus, input logic din);
    case (fbd_src_t'(src))
      FBD_SRC_DIGITAL: fbd_gate = din;
      FBD_SRC_BUS: fbd_gate = bus;
      FBD_SRC_OR: fbd_gate = bus | din;
      FBD_SRC_AND: fbd_gate = bus & din;
      default: fbd_gate = din;
    endcase
  endfunction

  function automatic logic signed [15:0] fbd_sat(input logic signed [16:0] v);
    if (v > 17'(FBD_REF_MAX))
      fbd_sat = FBD_REF_MAX;
    else if (v < 17'(FBD_REF_MIN))
      fbd_sat = FBD_REF_MIN;
    else
      fbd_sat = v[15:0];
  endfunction

  // ****************************************
  // decode of the latched word
  // ****************************************
  wire [1:0] src_coast = cfg_reg[FBD_CFG_COAST_LSB +: 2];
  wire [1:0] src_qstop = cfg_reg[FBD_CFG_QSTOP_LSB +: 2];
  wire [1:0] src_start = cfg_reg[FBD_CFG_START_LSB +: 2];
  wire [1:0] src_rev = cfg_reg[FBD_CFG_REV_LSB +: 2];
  wire [1:0] src_set = cfg_reg[FBD_CFG_SETSEL_LSB +: 2];
  wire [3:0] act_set_mode = cfg_reg[FBD_CFG_ACTSET_LSB +: 4];
  wire relay_en = cfg_reg[FBD_CFG_RELAY];

  wire no_coast = fbd_gate(src_coast, cmd_reg[FBD_B_COAST], i_din_coast_n);
  wire no_qstop = fbd_gate(src_qstop, cmd_reg[FBD_B_QSTOP], i_din_qstop_n);
  wire start_bit = fbd_gate(src_start, cmd_reg[FBD_B_RSTOP], i_din_start);
  wire off2 = !cmd_reg[FBD_B_OFF2];
  wire off3 = !cmd_reg[FBD_B_OFF3];
  wire off1 = !cmd_reg[FBD_B_OFF1];
  wire coast_req = off2 || !no_coast;
  wire qstop_req = !coast_req && (off3 || !no_qstop);
  wire ramp_req = !coast_req && !qstop_req && (off1 || !start_bit);
  // jog needs bits 00-03 high and bit 04 low
  wire jog_ok = (&cmd_reg[FBD_B_COAST:FBD_B_OFF1]) && !cmd_reg[FBD_B_QSTOP];
  wire rev_on = (fbd_src_t'(src_rev) != FBD_SRC_DIGITAL) ?
                fbd_gate(src_rev, cmd_reg[FBD_B_REV], i_din_rev) : i_din_rev;
  wire [1:0] bus_set = {cmd_reg[FBD_B_SET_MSB], cmd_reg[FBD_B_SET_LSB]};
  wire [1:0] req_set = (fbd_src_t'(src_set) == FBD_SRC_DIGITAL) ? i_din_set :
                       (fbd_src_t'(src_set) == FBD_SRC_BUS) ? bus_set :
                       (fbd_src_t'(src_set) == FBD_SRC_OR) ? (bus_set | i_din_set) :
                       (bus_set & i_din_set);
  wire multi = (act_set_mode == FBD_ACTSET_MULTI);
  wire linked = link_reg[set_reg] && link_reg[req_set];
  wire set_ok = multi && (!i_running || linked || (req_set == set_reg));

  // slow-down wins over catch-up
  wire signed [16:0] ref_wide = {ref_reg[15], ref_reg};
  wire signed [16:0] trim_wide = {trim_reg[15], trim_reg};
  wire signed [15:0] ref_trim = cmd_reg[FBD_B_SLOW] ? fbd_sat(ref_wide - trim_wide) :
                                cmd_reg[FBD_B_CATCH] ? fbd_sat(ref_wide + trim_wide) :
                                ref_reg;

  always_comb begin
    cmd_next = cmd_reg;
    ref_next = ref_reg;
    if (tel_valid) begin
      cmd_next = tel_cmd;
      ref_next = i_pwdata[15:0];
    end
  end

  assign set_next = set_ok ? req_set : set_reg;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cmd_reg <= 16'h0000;
      ref_reg <= 16'sh0000;
      pend_cmd_reg <= 16'h0000;
      cfg_reg <= FBD_CFG_RESET;
      trim_reg <= 16'sh0000;
      link_reg <= 4'h0;
      reset_prev_reg <= 1'b0;
      fault_reset_reg <= 1'b0;
      set_reg <= 2'h0;
      ref_out_reg <= 16'sh0000;
      freq_reg <= 16'h0000;
      drop_cnt_reg <= 16'h0000;
    end else begin
      cmd_reg <= cmd_next;
      ref_reg <= ref_next;
      if (wr && hit_cmd)
        pend_cmd_reg <= i_pwdata[15:0];
      if (wr && hit_cfg)
        cfg_reg <= i_pwdata;
      if (wr && hit_trim)
        trim_reg <= i_pwdata[15:0];
      if (wr && hit_link)
        link_reg <= i_pwdata[3:0];
      if (telegram && !tel_valid)
        drop_cnt_reg <= drop_cnt_reg + 16'h0001;
      reset_prev_reg <= cmd_reg[FBD_B_RESET];
      fault_reset_reg <= cmd_reg[FBD_B_RESET] && !reset_prev_reg;
      set_reg <= set_next;
      if (!o_hold)
        ref_out_reg <= ref_trim;
      freq_reg <= i_out_freq_rel;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_coast = coast_req;
  assign o_quick_stop = qstop_req;
  assign o_ramp_stop = ramp_req;
  assign o_hold = !cmd_reg[FBD_B_HOLD];
  assign o_start_ok = !coast_req && !qstop_req && !ramp_req;
  assign o_fault_reset = fault_reset_reg;
  assign o_jog1 = jog_ok && cmd_reg[FBD_B_JOG1];
  assign o_jog2 = jog_ok && cmd_reg[FBD_B_JOG2];
  assign o_reverse = rev_on;
  assign o_active_set = set_reg;
  assign o_speed_ref = ref_out_reg;
  assign o_stop_relay = relay_en && i_zero_freq && (off1 || off2 || off3);

  wire [31:0] stat_word = {16'h0000, 4'h0, o_stop_relay, o_reverse, o_active_set,
                           o_jog2, o_jog1, o_fault_reset, o_start_ok,
                           o_hold, o_ramp_stop, o_quick_stop, o_coast};
  always_comb begin
    o_prdata = 32'h0000_0000;
    if (acc && !i_pwrite) begin
      if (hit_cmd)
        o_prdata = {16'h0000, cmd_reg};
      else if (hit_ref)
        o_prdata = {16'h0000, ref_reg};
      else if (hit_cfg)
        o_prdata = cfg_reg;
      else if (hit_trim)
        o_prdata = {16'h0000, trim_reg};
      else if (hit_stat)
        o_prdata = stat_word;
      else if (hit_freq)
        o_prdata = {16'h0000, freq_reg};
      else if (hit_req)
        o_prdata = {drop_cnt_reg, o_speed_ref};
      else if (hit_link)
        o_prdata = {28'h000_0000, link_reg};
    end
  end
endmodule
`default_nettype wire

// file: core/fbd_pkg.sv
/*
  package for the fieldbus drive command decoder: register offsets,
  command word bit positions, gating modes and scaling constants.
  assumes one 40 MHz system clock and an APB master with 32-bit data.
*/
package fbd_pkg;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] FBD_OFF_CMD = 8'h00;
  localparam logic [7:0] FBD_OFF_REF = 8'h04;
  localparam logic [7:0] FBD_OFF_CFG = 8'h08;
  localparam logic [7:0] FBD_OFF_TRIM = 8'h0C;
  localparam logic [7:0] FBD_OFF_STAT = 8'h10;
  localparam logic [7:0] FBD_OFF_FREQ = 8'h14;
  localparam logic [7:0] FBD_OFF_REQ = 8'h18;
  localparam logic [7:0] FBD_OFF_LINK = 8'h1C;

  // ****************************************
  // command word bit positions
  // ****************************************
  localparam int FBD_B_OFF1 = 0;
  localparam int FBD_B_OFF2 = 1;
  localparam int FBD_B_OFF3 = 2;
  localparam int FBD_B_COAST = 3;
  localparam int FBD_B_QSTOP = 4;
  localparam int FBD_B_HOLD = 5;
  localparam int FBD_B_RSTOP = 6;
  localparam int FBD_B_RESET = 7;
  localparam int FBD_B_JOG1 = 8;
  localparam int FBD_B_JOG2 = 9;
  localparam int FBD_B_VALID = 10;
  localparam int FBD_B_SLOW = 11;
  localparam int FBD_B_CATCH = 12;
  localparam int FBD_B_SET_LSB = 13;
  localparam int FBD_B_SET_MSB = 14;
  localparam int FBD_B_REV = 15;

  // ****************************************
  // configuration register fields
  // ****************************************
  localparam int FBD_CFG_COAST_LSB = 0;
  localparam int FBD_CFG_QSTOP_LSB = 2;
  localparam int FBD_CFG_START_LSB = 4;
  localparam int FBD_CFG_REV_LSB = 6;
  localparam int FBD_CFG_SETSEL_LSB = 8;
  localparam int FBD_CFG_ACTSET_LSB = 10;
  localparam int FBD_CFG_RELAY = 14;
  localparam logic [31:0] FBD_CFG_RESET = 32'h0000_0000;
  localparam logic [3:0] FBD_ACTSET_MULTI = 4'h9;

  // gating source of a command bit against its digital input
  typedef enum logic [1:0] {
    FBD_SRC_DIGITAL = 2'h0,
    FBD_SRC_BUS = 2'h1,
    FBD_SRC_OR = 2'h2,
    FBD_SRC_AND = 2'h3
  } fbd_src_t;

  // ****************************************
  // reference scaling
  // ****************************************
  localparam logic signed [15:0] FBD_REF_100PCT = 16'sh4000;
  localparam logic signed [15:0] FBD_REF_MAX = 16'sh7FFF;
  localparam logic signed [15:0] FBD_REF_MIN = 16'sh8000;
endpackage

// file: tb/fbd_decoder_asserts.sv
/* port checker for fbd_decoder.
   assumes a bind from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module fbd_decoder_chk (
  input wire logic i_clk_sys, // clock
  input wire logic i_srst, // reset
  input wire logic i_psel, // select
  input wire logic i_penable, // enable
  input wire logic i_pwrite, // write
  input wire logic [7:0] i_paddr, // address
  input wire logic [31:0] i_pwdata, // data
  input wire logic i_zero_freq, // at 0 Hz
  input wire logic o_coast, // coast
  input wire logic o_quick_stop, // quick stop
  input wire logic o_ramp_stop, // ramp stop
  input wire logic o_start_ok, // start ok
  input wire logic o_hold, // hold
  input wire logic o_fault_reset, // reset pulse
  input wire logic o_jog1, // jog 1
  input wire logic o_jog2, // jog 2
  input wire logic signed [15:0] o_speed_ref, // reference
  input wire logic o_stop_relay // relay
);
  import fbd_pkg::*;
  // ****
  // pending command tracking
  // ****
  logic [15:0] pend_reg;
  wire logic wr = i_psel && i_penable && i_pwrite;
  wire logic wr_ref = wr && (i_paddr == FBD_OFF_REF);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pend_reg <= '0;
    end else if (wr && (i_paddr == FBD_OFF_CMD)) begin
      pend_reg <= i_pwdata[15:0];
    end
  end
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  relay_rest_a: assert property (
    o_stop_relay |-> i_zero_freq && (o_ramp_stop || o_coast || o_quick_stop))
    else $error("relay away from standstill");
  coast_excl_a: assert property (
    o_coast |-> !o_start_ok && !o_quick_stop && !o_ramp_stop)
    else $error("coast with other request");
  quick_excl_a: assert property (o_quick_stop |-> !o_start_ok)
    else $error("quick stop with start");
  hold_freeze_a: assert property (o_hold |=> $stable(o_speed_ref))
    else $error("reference moved in hold");
  fault_pulse_a: assert property (o_fault_reset |=> !o_fault_reset)
    else $error("fault reset too long");
  fault_cause_a: assert property (
    o_fault_reset |-> $past(wr_ref, 1) || $past(wr_ref, 2) || $past(wr_ref, 3))
    else $error("fault reset without telegram");
  jog_cause_a: assert property (
    $changed(o_jog1) || $changed(o_jog2) |-> $past(wr_ref, 1) || $past(wr_ref, 2))
    else $error("jog moved without telegram");
  ignore_inval_a: assert property (
    wr_ref && !pend_reg[FBD_B_VALID] |=> $stable(o_jog1) && $stable(o_hold)
      ##1 $stable(o_speed_ref))
    else $error("invalid telegram took effect");
endmodule
`default_nettype wire

// file: tb/fbd_motor_model.sv
/* motor core model: frequency follows the reference one cycle late.
   assumes run permission is formed by the bench. */
`timescale 1ns/10ps
`default_nettype none
module fbd_motor_model (
  input wire logic i_clk_sys, // clock
  input wire logic i_srst, // reset
  input wire logic i_go, // run allowed
  input wire logic signed [15:0] i_target, // reference
  output logic signed [15:0] o_freq, // actual frequency
  output logic o_running, // turning
  output logic o_zero // at 0 Hz
);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_go) begin
      o_freq <= '0;
    end else begin
      o_freq <= i_target;
    end
  end
  assign o_running = (o_freq != 16'sh0000);
  assign o_zero = (o_freq == 16'sh0000);
endmodule
`default_nettype wire

// file: tb/fbd_tb_top.sv
/* bench top for fbd_decoder with motor model and checker.
   assumes package, design, model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module fieldbus_drive_command_decoder_tb_top;
  import fbd_pkg::*;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, din_rev = 0, err;
  logic din_coast_n = 1, din_qstop_n = 1;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, coast, qstop, rstop, hold, start_ok, fres, jog1, jog2;
  logic rev, relay, running, zero;
  logic [1:0] aset;
  logic signed [15:0] sref, freq;
  int errors = 0, samples_checked = 0, cyc = 0, pulses = 0, n0;
  logic [15:0] tc[6] = '{16'h0C7F, 16'h147F, 16'h1C7F, 16'h147F, 16'h147F, 16'h0C7F};
  logic [15:0] tr[6] = '{16'h4000, 16'h4000, 16'h4000, 16'hC000, 16'h7FFF, 16'h8000};
  logic [15:0] te[6] = '{16'h3F00, 16'h4100, 16'h3F00, 16'hC100, 16'h7FFF, 16'h8000};
  always #12.5 clk = ~clk;
  fbd_decoder i_fbd_decoder (.i_clk_sys(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_din_coast_n(din_coast_n), .i_din_qstop_n(din_qstop_n),
    .i_din_start(1'b0),
    .i_din_rev(din_rev), .i_din_set(2'b00), .i_running(running), .i_zero_freq(zero),
    .i_out_freq_rel(freq), .o_ramp_stop(rstop), .o_coast(coast), .o_quick_stop(qstop),
    .o_hold(hold), .o_start_ok(start_ok), .o_fault_reset(fres), .o_jog1(jog1), .o_jog2(jog2),
    .o_reverse(rev), .o_active_set(aset), .o_speed_ref(sref), .o_stop_relay(relay));
  fbd_motor_model i_fbd_motor_model (.i_clk_sys(clk), .i_srst(srst),
    .i_go(start_ok && !coast && !qstop && !rstop), .i_target(sref), .o_freq(freq),
    .o_running(running), .o_zero(zero));
  // ****
  // bus and check tasks
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tel(input logic [15:0] c, input logic [15:0] r);
    apb(1'b1, FBD_OFF_CMD, {16'h0000, c});
    apb(1'b1, FBD_OFF_REF, {16'h0000, r});
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (fres === 1'b1) pulses++;
    if (cyc == 3000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    chk(coast, 1);
    chk(sref, 0);
    apb(1'b0, FBD_OFF_STAT, 32'h0000_0000);
    chk(q[15:0], 16'h0009);
    apb(1'b1, FBD_OFF_CFG, 32'h0000_6555);
    tel(16'h047F, 16'h1000);
    chk(start_ok, 1);
    chk(sref, 16'h1000);
    apb(1'b0, FBD_OFF_FREQ, 32'h0000_0000);
    chk(q[15:0], 16'h1000);
    tel(16'h007F, 16'h3000);
    chk(sref, 16'h1000);
    apb(1'b0, FBD_OFF_REQ, 32'h0000_0000);
    chk(q[31:16], 16'h0001);
    tel(16'h045F, 16'h2000);
    chk(sref, 16'h1000);
    chk(hold, 1);
    $display("test run ignore hold done");
    apb(1'b1, FBD_OFF_TRIM, 32'h0000_0100);
    for (int i = 0; i < 6; i++) begin
      tel(tc[i], tr[i]);
      chk(sref, te[i]);
    end
    n0 = pulses;
    tel(16'h04FF, 16'h0000);
    tel(16'h04FF, 16'h0000);
    chk(16'(pulses - n0), 1);
    tel(16'h050F, 16'h0000);
    chk(jog1, 1);
    tel(16'h051F, 16'h0000);
    chk(jog1, 0);
    tel(16'h060F, 16'h0000);
    chk(jog2, 1);
    tel(16'h0607, 16'h0000);
    chk(jog2, 0);
    for (int s = 0; s < 4; s++) begin
      tel({1'b0, s[1:0], 13'h047F}, 16'h0000);
      chk(aset, s[1:0]);
    end
    apb(1'b1, FBD_OFF_CFG, 32'h0000_4155);
    tel(16'h047F, 16'h0000);
    chk(aset, 2'h3);
    apb(1'b1, FBD_OFF_CFG, 32'h0000_6555);
    tel(16'h647F, 16'h1000);
    tel(16'h047F, 16'h1000);
    chk(aset, 2'h3);
    apb(1'b1, FBD_OFF_LINK, 32'h0000_0009);
    repeat (2) @(posedge clk);
    chk(aset, 2'h0);
    $display("test trim reset jog set done");
    tel(16'h847F, 16'h0000);
    chk(rev, 1);
    apb(1'b1, FBD_OFF_CFG, 32'h0000_6515);
    @(posedge clk);
    chk(rev, 0);
    din_rev <= 1'b1;
    din_coast_n <= 1'b0;
    apb(1'b1, FBD_OFF_CFG, 32'h0000_6517);
    @(posedge clk);
    chk({rev, coast}, 2'b11);
    din_coast_n <= 1'b1;
    din_qstop_n <= 1'b0;
    apb(1'b1, FBD_OFF_CFG, 32'h0000_6513);
    @(posedge clk);
    chk({qstop, coast}, 2'b10);
    din_qstop_n <= 1'b1;
    for (int b = 0; b < 3; b++) begin
      tel(16'h047F & ~(16'h0001 << b), 16'h1000);
      chk({qstop, coast, rstop}, 3'b001 << b);
      chk(relay, 1);
    end
    tel(16'h047F, 16'h1000);
    chk(relay, 0);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(err, 1);
    $display("test reverse relay bus done");
    close_out();
  end
endmodule
bind fbd_decoder fbd_decoder_chk i_fbd_decoder_chk (.i_clk_sys, .i_srst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_zero_freq, .o_coast, .o_quick_stop, .o_ramp_stop,
  .o_start_ok, .o_hold, .o_fault_reset, .o_jog1, .o_jog2, .o_speed_ref, .o_stop_relay);
`default_nettype wire
